//--- common/rgfc_pkg.sv
// Constants for the gain loop and front-end trim register bank
package rgfc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [15:0] RGFC_GAIN_CTRL_IDX = 16'hdf19;
  localparam logic [15:0] RGFC_RX_TRIM_IDX = 16'hdf1a;
  localparam logic [15:0] RGFC_TX_TRIM_IDX = 16'hdf1b;
  localparam logic [15:0] RGFC_SENSE_IDX = 16'hdf30;
  localparam logic [15:0] RGFC_STATUS_IDX = 16'hdf31;

  // ****************************************************************
  // Field positions (low bit of each field)
  // ****************************************************************
  localparam int RGFC_HYST_POS = 6;
  localparam int RGFC_WAIT_POS = 4;
  localparam int RGFC_HOLD_POS = 2;
  localparam int RGFC_FLEN_POS = 0;
  localparam int RGFC_RX_AMP_POS = 6;
  localparam int RGFC_RX_A2M_POS = 4;
  localparam int RGFC_RX_LO_POS = 2;
  localparam int RGFC_RX_MIX_POS = 0;
  localparam int RGFC_TX_LO_POS = 4;
  localparam int RGFC_THR_POS = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RGFC_HYST_RST = 2'h2;
  localparam logic [1:0] RGFC_WAIT_RST = 2'h1;
  localparam logic [1:0] RGFC_HOLD_RST = 2'h0;
  localparam logic [1:0] RGFC_FLEN_RST = 2'h1;
  localparam logic [1:0] RGFC_RX_AMP_RST = 2'h1;
  localparam logic [1:0] RGFC_RX_A2M_RST = 2'h1;
  localparam logic [1:0] RGFC_RX_LO_RST = 2'h1;
  localparam logic [1:0] RGFC_RX_MIX_RST = 2'h2;
  localparam logic [1:0] RGFC_TX_LO_RST = 2'h1;
  localparam logic [3:0] RGFC_THR_RST = 4'h0;

  // Most negative threshold code switches absolute sensing off
  localparam logic [3:0] RGFC_THR_OFF = 4'h8;

  // Gain hold modes
  localparam logic [1:0] RGFC_HOLD_NONE = 2'h0;
  localparam logic [1:0] RGFC_HOLD_SYNC = 2'h1;
  localparam logic [1:0] RGFC_HOLD_ANALOG = 2'h2;
  localparam logic [1:0] RGFC_HOLD_ALL = 2'h3;

  // Sample counts: settle wait step and shortest averaging length
  localparam logic [5:0] RGFC_WAIT_STEP = 6'h08;
  localparam logic [6:0] RGFC_AVG_BASE = 7'h08;

  // Gain loop states, one-hot
  typedef enum logic [1:0] {
    RGFC_ACCUM = 2'b01,
    RGFC_SETTLE = 2'b10
  } rgfc_state_t;

endpackage

//--- core/rgfc_bank.sv
// Gain loop control and front-end trim register bank with its gain loop sequencer
// Behaviour
// - Threshold is signed 4-bit, 1 dB steps
// - Code 1000 disables absolute carrier sensing
// - Bits 7:6 pick hysteresis, reset medium
// - Skip 8/16/24/32 samples after gain step
// - Hold mode 0 always adjusts gain
// - Hold mode 1 freezes gain after sync
// - Hold mode 2 holds analog, digital adjusts
// - Hold mode 3 holds analog and digital
// - Bits 1:0 pick averaging 8/16/32/64
// - Four receive trims, reset 01,01,01,10
// - Transmit LO trim bits 5:4, reset 01
`timescale 1ns/1ns
`default_nettype none

module rgfc_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic adjust_req,
  input wire logic sync_found,
  input wire logic rx_restart,
  output logic [1:0] gain_hysteresis_level,
  output logic [1:0] gain_hold_select,
  output logic [6:0] avg_length,
  output logic [5:0] settle_length,
  output logic accumulate_en,
  output logic avg_done,
  output logic analog_step,
  output logic digital_step,
  output logic analog_hold,
  output logic digital_hold,
  output logic signed [3:0] abs_sense_threshold,
  output logic abs_sense_enable,
  output logic [1:0] rx_amp_bias_trim,
  output logic [1:0] rx_amp_to_mixer_trim,
  output logic [1:0] rx_lo_buffer_trim,
  output logic [1:0] rx_mixer_trim,
  output logic [1:0] tx_lo_buffer_trim
);

  // ****************************************************************
  // Decoders
  // ****************************************************************

  // Settle wait in samples: 8, 16, 24 or 32
  function automatic logic [5:0] rgfc_wait_len(input logic [1:0] sel);
    rgfc_wait_len = 6'(({4'h0, sel} + 6'h01) * rgfc_pkg::RGFC_WAIT_STEP);
  endfunction

  // Averaging length in samples: 8, 16, 32 or 64
  function automatic logic [6:0] rgfc_avg_len(input logic [1:0] sel);
    rgfc_avg_len = 7'(rgfc_pkg::RGFC_AVG_BASE << sel);
  endfunction

  // Hold flags from mode and sync state
  function automatic logic [1:0] rgfc_holds(input logic [1:0] mode, input logic frozen);
    logic ana;
    logic dig;
    ana = (mode == rgfc_pkg::RGFC_HOLD_ANALOG) || (mode == rgfc_pkg::RGFC_HOLD_ALL);
    dig = (mode == rgfc_pkg::RGFC_HOLD_ALL);
    if (mode == rgfc_pkg::RGFC_HOLD_SYNC && frozen) begin
      ana = 1'b1;
      dig = 1'b1;
    end
    rgfc_holds = {ana, dig};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] hyst;
    logic [1:0] wait_sel;
    logic [1:0] hold;
    logic [1:0] flen;
    logic [1:0] rx_amp;
    logic [1:0] rx_a2m;
    logic [1:0] rx_lo;
    logic [1:0] rx_mix;
    logic [1:0] tx_lo;
    logic [3:0] thr;
    logic thr_en;
    logic wait_n;
    logic [7:0] rdata;
    rgfc_pkg::rgfc_state_t state;
    logic [5:0] settle_cnt;
    logic [6:0] avg_cnt;
    logic frozen;
    logic avg_done;
    logic a_step;
    logic d_step;
    logic a_hold;
    logic d_hold;
    logic [6:0] avg_len;
    logic [5:0] wait_len;
  } rgfc_regs_t;

  rgfc_regs_t st_r;
  rgfc_regs_t st_nxt;

  logic [15:0] idx;
  logic hit;
  logic [1:0] holds;
  logic last_avg;

  // Word index of the access; byte lane bits must be zero
  assign idx = avs_address[17:2];
  assign hit = (avs_address[1:0] == 2'b00);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    holds = 2'b00;
    last_avg = 1'b0;
    st_nxt.avg_done = 1'b0;
    st_nxt.a_step = 1'b0;
    st_nxt.d_step = 1'b0;

    // Bus answer: one wait cycle, then a single cycle with waitrequest low
    if ((avs_read || avs_write) && st_r.wait_n) begin
      st_nxt.wait_n = 1'b0;
      st_nxt.rdata = 8'h00;
      if (avs_read && hit) begin
        unique case (idx)
          rgfc_pkg::RGFC_GAIN_CTRL_IDX:
            st_nxt.rdata = {st_r.hyst, st_r.wait_sel, st_r.hold, st_r.flen};
          rgfc_pkg::RGFC_RX_TRIM_IDX:
            st_nxt.rdata = {st_r.rx_amp, st_r.rx_a2m, st_r.rx_lo, st_r.rx_mix};
          rgfc_pkg::RGFC_TX_TRIM_IDX:
            st_nxt.rdata = {2'b00, st_r.tx_lo, 4'h0};
          rgfc_pkg::RGFC_SENSE_IDX:
            st_nxt.rdata = {4'h0, st_r.thr};
          rgfc_pkg::RGFC_STATUS_IDX:
            st_nxt.rdata = {5'h00, st_r.frozen, st_r.state == rgfc_pkg::RGFC_SETTLE,
                            st_r.state == rgfc_pkg::RGFC_ACCUM};
          default: st_nxt.rdata = 8'h00; // Unmapped reads as zero
        endcase
      end
    end else begin
      st_nxt.wait_n = 1'b1;
    end

    // Writes land on the edge where waitrequest is seen low
    if (avs_write && !st_r.wait_n && hit && avs_byteenable[0]) begin
      unique case (idx)
        rgfc_pkg::RGFC_GAIN_CTRL_IDX: begin
          st_nxt.hyst = avs_writedata[rgfc_pkg::RGFC_HYST_POS +: 2];
          st_nxt.wait_sel = avs_writedata[rgfc_pkg::RGFC_WAIT_POS +: 2];
          st_nxt.hold = avs_writedata[rgfc_pkg::RGFC_HOLD_POS +: 2];
          st_nxt.flen = avs_writedata[rgfc_pkg::RGFC_FLEN_POS +: 2];
        end
        rgfc_pkg::RGFC_RX_TRIM_IDX: begin
          st_nxt.rx_amp = avs_writedata[rgfc_pkg::RGFC_RX_AMP_POS +: 2];
          st_nxt.rx_a2m = avs_writedata[rgfc_pkg::RGFC_RX_A2M_POS +: 2];
          st_nxt.rx_lo = avs_writedata[rgfc_pkg::RGFC_RX_LO_POS +: 2];
          st_nxt.rx_mix = avs_writedata[rgfc_pkg::RGFC_RX_MIX_POS +: 2];
        end
        // Only the LO trim is stored; the reserved low bits are expected zero anyway
        rgfc_pkg::RGFC_TX_TRIM_IDX:
          st_nxt.tx_lo = avs_writedata[rgfc_pkg::RGFC_TX_LO_POS +: 2];
        rgfc_pkg::RGFC_SENSE_IDX:
          st_nxt.thr = avs_writedata[rgfc_pkg::RGFC_THR_POS +: 4];
        default: ; // Unmapped and read-only writes are dropped
      endcase
    end

    // Sensing enable follows the threshold code
    st_nxt.thr_en = (st_nxt.thr != rgfc_pkg::RGFC_THR_OFF);

    // Sync freeze: a sync event beats a restart in the same cycle
    if (rx_restart) begin
      st_nxt.frozen = 1'b0;
    end
    if (sync_found && st_r.hold == rgfc_pkg::RGFC_HOLD_SYNC) begin
      st_nxt.frozen = 1'b1;
    end

    // Gain loop sequencer
    holds = rgfc_holds(st_r.hold, st_r.frozen);
    last_avg = (st_r.avg_cnt >= st_r.avg_len - 7'h01);
    unique case (st_r.state)
      rgfc_pkg::RGFC_ACCUM: begin
        if (sample_valid) begin
          st_nxt.avg_cnt = st_r.avg_cnt + 7'h01;
          if (last_avg) begin
            st_nxt.avg_cnt = 7'h00;
            st_nxt.avg_done = 1'b1;
            // Mode 0 leaves both holds clear, so every request steps
            if (adjust_req && !holds[1]) begin
              st_nxt.a_step = 1'b1;
            end else if (adjust_req && !holds[0]) begin
              st_nxt.d_step = 1'b1;
            end
            if (adjust_req && !(holds[1] && holds[0])) begin
              st_nxt.state = rgfc_pkg::RGFC_SETTLE;
              st_nxt.settle_cnt = st_r.wait_len;
            end
          end
        end
      end
      rgfc_pkg::RGFC_SETTLE: begin
        if (sample_valid) begin
          st_nxt.settle_cnt = st_r.settle_cnt - 6'h01;
          if (st_r.settle_cnt <= 6'h01) begin
            st_nxt.state = rgfc_pkg::RGFC_ACCUM;
            st_nxt.avg_cnt = 7'h00;
          end
        end
      end
      default: begin
        st_nxt.state = rgfc_pkg::RGFC_ACCUM;
        st_nxt.avg_cnt = 7'h00;
      end
    endcase

    // Decoded settings, registered so outputs come from flops
    st_nxt.avg_len = rgfc_avg_len(st_nxt.flen);
    st_nxt.wait_len = rgfc_wait_len(st_nxt.wait_sel);
    {st_nxt.a_hold, st_nxt.d_hold} = rgfc_holds(st_nxt.hold, st_nxt.frozen);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.hyst <= rgfc_pkg::RGFC_HYST_RST;
      st_r.wait_sel <= rgfc_pkg::RGFC_WAIT_RST;
      st_r.hold <= rgfc_pkg::RGFC_HOLD_RST;
      st_r.flen <= rgfc_pkg::RGFC_FLEN_RST;
      st_r.rx_amp <= rgfc_pkg::RGFC_RX_AMP_RST;
      st_r.rx_a2m <= rgfc_pkg::RGFC_RX_A2M_RST;
      st_r.rx_lo <= rgfc_pkg::RGFC_RX_LO_RST;
      st_r.rx_mix <= rgfc_pkg::RGFC_RX_MIX_RST;
      st_r.tx_lo <= rgfc_pkg::RGFC_TX_LO_RST;
      st_r.thr <= rgfc_pkg::RGFC_THR_RST;
      st_r.thr_en <= 1'b1;
      st_r.wait_n <= 1'b1;
      st_r.rdata <= 8'h00;
      st_r.state <= rgfc_pkg::RGFC_ACCUM;
      st_r.settle_cnt <= 6'h00;
      st_r.avg_cnt <= 7'h00;
      st_r.frozen <= 1'b0;
      st_r.avg_done <= 1'b0;
      st_r.a_step <= 1'b0;
      st_r.d_step <= 1'b0;
      st_r.a_hold <= 1'b0;
      st_r.d_hold <= 1'b0;
      st_r.avg_len <= 7'h10;
      st_r.wait_len <= 6'h10;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, each a field of the state register
  // ****************************************************************
  assign avs_readdata = {24'h00_0000, st_r.rdata};
  assign avs_waitrequest = st_r.wait_n;
  assign gain_hysteresis_level = st_r.hyst;
  assign gain_hold_select = st_r.hold;
  assign avg_length = st_r.avg_len;
  assign settle_length = st_r.wait_len;
  assign accumulate_en = st_r.state[0]; // One-hot accumulate bit, straight from the flop
  assign avg_done = st_r.avg_done;
  assign analog_step = st_r.a_step;
  assign digital_step = st_r.d_step;
  assign analog_hold = st_r.a_hold;
  assign digital_hold = st_r.d_hold;
  assign abs_sense_threshold = st_r.thr;
  assign abs_sense_enable = st_r.thr_en;
  assign rx_amp_bias_trim = st_r.rx_amp;
  assign rx_amp_to_mixer_trim = st_r.rx_a2m;
  assign rx_lo_buffer_trim = st_r.rx_lo;
  assign rx_mixer_trim = st_r.rx_mix;
  assign tx_lo_buffer_trim = st_r.tx_lo;

endmodule // rgfc_bank

`default_nettype wire

//--- sim/rgfc_bank_properties.sv
// Checker for the gain loop register bank, bound to its top module
`timescale 1ns/1ns
`default_nettype none

module rgfc_bank_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sync_found,
  input wire logic [1:0] gain_hold_select,
  input wire logic [6:0] avg_length,
  input wire logic [5:0] settle_length,
  input wire logic accumulate_en,
  input wire logic avg_done,
  input wire logic analog_step,
  input wire logic digital_step,
  input wire logic analog_hold,
  input wire logic digital_hold,
  input wire logic signed [3:0] abs_sense_threshold,
  input wire logic abs_sense_enable
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Bus answers after exactly one wait cycle, then waits again
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_sense_off: assert property (abs_sense_enable == (abs_sense_threshold != 4'sh8))
    else $error("sense enable wrong");
  chk_avg_legal: assert property (avg_length inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("averaging length illegal");
  chk_settle_legal: assert property (settle_length inside {6'h08, 6'h10, 6'h18, 6'h20})
    else $error("settle length illegal");
  chk_step_window: assert property (analog_step || digital_step |-> avg_done && !accumulate_en)
    else $error("step outside window end");
  chk_all_held: assert property ($past(gain_hold_select == 2'h3) |-> !analog_step && !digital_step)
    else $error("step while all held");
  chk_analog_held: assert property ($past(gain_hold_select == 2'h2) |-> !analog_step)
    else $error("analog step while held");
  chk_sync_freeze: assert property (sync_found && gain_hold_select == 2'h1 |=> analog_hold && digital_hold)
    else $error("sync did not freeze");
endmodule // rgfc_bank_checker

bind rgfc_bank rgfc_bank_checker u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sync_found(sync_found), .gain_hold_select(gain_hold_select), .avg_length(avg_length),
  .settle_length(settle_length), .accumulate_en(accumulate_en), .avg_done(avg_done),
  .analog_step(analog_step), .digital_step(digital_step), .analog_hold(analog_hold),
  .digital_hold(digital_hold), .abs_sense_threshold(abs_sense_threshold),
  .abs_sense_enable(abs_sense_enable));

`default_nettype wire

//--- sim/rgfc_bank_bench.sv
// Self-checking bench for the gain loop register bank
`timescale 1ns/1ns
`default_nettype none

module rgfc_bank_bench;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, sample_valid, adjust_req;
  logic sync_found, rx_restart, accumulate_en, avg_done, analog_step, digital_step;
  logic analog_hold, digital_hold, abs_sense_enable;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [1:0] hyst, hold, amp, a2m, rlo, mix, tlo;
  logic [6:0] avg_length;
  logic [5:0] settle_length;
  logic signed [3:0] thr;
  logic [3:0] codes [6] = '{4'h9, 4'hf, 4'h0, 4'h1, 4'h7, 4'h8};
  int failures = 0;
  int comparisons = 0;

  rgfc_bank u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .adjust_req(adjust_req), .sync_found(sync_found),
    .rx_restart(rx_restart), .gain_hysteresis_level(hyst), .gain_hold_select(hold),
    .avg_length(avg_length), .settle_length(settle_length), .accumulate_en(accumulate_en),
    .avg_done(avg_done), .analog_step(analog_step), .digital_step(digital_step),
    .analog_hold(analog_hold), .digital_hold(digital_hold), .abs_sense_threshold(thr),
    .abs_sense_enable(abs_sense_enable), .rx_amp_bias_trim(amp), .rx_amp_to_mixer_trim(a2m),
    .rx_lo_buffer_trim(rlo), .rx_mixer_trim(mix), .tx_lo_buffer_trim(tlo));

  // 25 MHz clock
  always #20 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      failures++;
      test_done;
    end
    #1;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk("readdata", {24'h00_0000, exp}, q);
  endtask

  // Back-to-back samples; flags are looked at after the last one lands
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk);
      sample_valid <= 1'b1;
    end
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
  endtask

  // One 8-sample window, then the 8-sample settle if a step was granted;
  // the settle is split so an early return to accumulating is caught
  task automatic win(input logic a, input logic d);
    burst(8);
    chk("avg_done", 1, avg_done);
    chk("steps", {a, d}, {analog_step, digital_step});
    if (a | d) begin
      chk("accumulate_en", 0, accumulate_en);
      burst(7);
      chk("accumulate_en", 0, accumulate_en);
      burst(1);
      chk("accumulate_en", 1, accumulate_en);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {clk, avs_read, avs_write, sample_valid, adjust_req, sync_found, rx_restart} = '0;
    rst = 1'b1;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(rgfc_pkg::RGFC_GAIN_CTRL_IDX, 8'h91);
    rd(rgfc_pkg::RGFC_RX_TRIM_IDX, 8'h56);
    rd(rgfc_pkg::RGFC_TX_TRIM_IDX, 8'h10);
    bus(1'b1, rgfc_pkg::RGFC_TX_TRIM_IDX, 8'hf8);
    rd(rgfc_pkg::RGFC_TX_TRIM_IDX, 8'h30);
    chk("tx_lo", 3, tlo);
    // A write with the low byte lane disabled must leave the trim alone
    @(posedge clk);
    avs_byteenable <= 4'h0;
    bus(1'b1, rgfc_pkg::RGFC_TX_TRIM_IDX, 8'h00);
    chk("tx_lo", 3, tlo);
    @(posedge clk);
    avs_byteenable <= 4'h1;
    bus(1'b1, rgfc_pkg::RGFC_RX_TRIM_IDX, 8'h1b);
    chk("rx_trims", 32'h0000_001b, {amp, a2m, rlo, mix});
    rd(16'h1234, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, rgfc_pkg::RGFC_GAIN_CTRL_IDX, {i[1:0], i[1:0], 2'b00, i[1:0]});
      chk("hysteresis", i, hyst);
      chk("settle_length", 8 * (i + 1), settle_length);
      chk("avg_length", 8 << i, avg_length);
    end
    // Threshold codes across the signed range, including the off code
    foreach (codes[k]) begin
      bus(1'b1, rgfc_pkg::RGFC_SENSE_IDX, {4'h0, codes[k]});
      chk("threshold", codes[k], {28'h000_0000, thr});
      chk("sense_enable", codes[k] != 4'h8, abs_sense_enable);
    end
    rd(rgfc_pkg::RGFC_SENSE_IDX, 8'h08);
    @(posedge clk);
    adjust_req <= 1'b1;
    bus(1'b1, rgfc_pkg::RGFC_GAIN_CTRL_IDX, 8'h00);
    win(1'b1, 1'b0);
    bus(1'b1, rgfc_pkg::RGFC_GAIN_CTRL_IDX, 8'h08);
    chk("holds", 2, {analog_hold, digital_hold});
    win(1'b0, 1'b1);
    bus(1'b1, rgfc_pkg::RGFC_GAIN_CTRL_IDX, 8'h0c);
    chk("holds", 3, {analog_hold, digital_hold});
    win(1'b0, 1'b0);
    bus(1'b1, rgfc_pkg::RGFC_GAIN_CTRL_IDX, 8'h04);
    chk("hold_select", 1, hold);
    @(posedge clk);
    sync_found <= 1'b1;
    @(posedge clk);
    sync_found <= 1'b0;
    #1;
    chk("holds", 3, {analog_hold, digital_hold});
    rd(rgfc_pkg::RGFC_STATUS_IDX, 8'h05);
    win(1'b0, 1'b0);
    @(posedge clk);
    rx_restart <= 1'b1;
    @(posedge clk);
    rx_restart <= 1'b0;
    #1;
    chk("holds", 0, {analog_hold, digital_hold});
    win(1'b1, 1'b0);
    test_done;
  end
endmodule // rgfc_bank_bench

`default_nettype wire
